// ===== design/acg_pkg.sv
// Package of register offsets, fields, reset values and counts for the converter configuration.
// Overview of operation
// - When the gain add bit is set, one sixty-fourth is added to the gain from the gain high and low registers.
// - The conversion clock is the source clock divided by the 5-bit divider field in bits 7:3 plus one.
// - With burst mode off, the divider source is the system clock.
// - With burst mode on, the divider source is an internal clock of at most 30 MHz.
// - The 2-bit repeat count in bits 2:1 sets how many conversions are summed between completion events.
// - Repeat code 00 takes one conversion, 01 sums four and 10 sums eight.
// - In burst mode one start trigger launches the whole series of self-timed conversions.
// - Configuration bit 0 steers result register writes to the indirect gain path.
// - While gain programming is on, a result high write selects the gain index and a result low write loads it.
// - The gain word is 12 bits from the gain high register and the upper nibble of the gain low register.
// - Repeat code 11 yields a 16-bit sum whose upper byte fills the result high register.
package acg_pkg;
   localparam logic [7:0] ADDR_CONFIG = 8'hbc;
   localparam logic [7:0] ADDR_RESULT_HIGH = 8'hbe;
   localparam logic [7:0] ADDR_RESULT_LOW = 8'hbd;
   localparam logic [7:0] IDX_GAIN_HIGH = 8'h04;
   localparam logic [7:0] IDX_GAIN_LOW = 8'h07;
   localparam logic [7:0] IDX_ADDITIONAL_GAIN = 8'h08;
   localparam logic [7:0] RST_CONFIG = 8'hf8;
   localparam logic [7:0] RST_GAIN_HIGH = 8'hfc;
   localparam logic [7:0] RST_GAIN_LOW = 8'h00;
   localparam logic [7:0] RST_ADDITIONAL_GAIN = 8'h01;
   localparam int CFG_DIV_MSB = 7;
   localparam int CFG_DIV_LSB = 3;
   localparam int CFG_RPT_MSB = 2;
   localparam int CFG_RPT_LSB = 1;
   localparam int CFG_GAIN_EN = 0;
   localparam int GAIN_ADD_BIT = 0;
   localparam int BURST_CLK_MAX_MHZ = 30;
   localparam int SYS_CLK_MHZ = 100;
   // Divide the system clock down so the burst source never exceeds its ceiling.
   localparam int BURST_PRESCALE_CYC = (SYS_CLK_MHZ + BURST_CLK_MAX_MHZ - 1) / BURST_CLK_MAX_MHZ;
   localparam int GAIN_ADD_SCALED = 4096 / 64;
   typedef enum logic [1:0] {
      ACG_IDLE = 2'b00,
      ACG_WAIT = 2'b01,
      ACG_CONV = 2'b10
   } acg_state_t;
endpackage

// ===== design/acg_divider.sv
// Conversion clock divider: one tick per divide value plus one source ticks.
`timescale 1ns/10ps
module acg_divider #(
   parameter int W = 5
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic src_tick,
   input wire logic [W-1:0] divide,
   output logic sar_tick
);
   if (W < 1) begin : g_bad_width
      $error("acg_divider width must be at least one");
   end
   logic [W-1:0] cnt_q;
   wire logic wrap = (cnt_q >= divide);
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
         sar_tick <= 1'b0;
      end else begin
         sar_tick <= src_tick && wrap;
         if (src_tick) begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
         end
      end
   end
endmodule // acg_divider

// ===== design/acg_config.sv
// Converter configuration, indirect gain registers and repeat accumulation.
`timescale 1ns/10ps
module acg_config #(
   parameter int CONV_TICKS = 13,
   parameter int ACC_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   output logic [7:0] sfr_rdata,
   input wire logic burst_enable,
   input wire logic conv_start,
   input wire logic sample_valid,
   input wire logic [11:0] sample_data,
   output logic sar_conversion_clock,
   output logic conv_request,
   output logic conversion_done_flag,
   output logic window_compare_flag,
   output logic [11:0] gain_word,
   output logic gain_add_bit,
   output logic busy
);
   if (CONV_TICKS < 1 || CONV_TICKS > 255) begin : g_bad_ticks
      $error("CONV_TICKS out of range");
   end
   if (ACC_W != 16) begin : g_bad_acc
      $error("ACC_W must be 16");
   end
   // The burst prescaler counter is only two bits wide.
   if (acg_pkg::BURST_PRESCALE_CYC < 1 || acg_pkg::BURST_PRESCALE_CYC > 4) begin : g_bad_pre
      $error("burst prescale does not fit its counter");
   end

   logic [7:0] converter_config_reg_q;
   logic [7:0] gain_index_q;
   logic [7:0] gain_high_reg_q;
   logic [7:0] gain_low_reg_q;
   logic [7:0] additional_gain_reg_q;
   logic [ACC_W-1:0] acc_q;
   logic [3:0] done_cnt_q;
   logic [7:0] tick_cnt_q;
   logic [1:0] pre_q;
   logic src_tick_q;
   logic sar_tick;
   logic conv_start_s1_q;
   logic conv_start_s2_q;
   logic conv_start_s3_q;
   acg_pkg::acg_state_t state_q;

   wire logic gain_prog = converter_config_reg_q[acg_pkg::CFG_GAIN_EN];
   wire logic [1:0] rpt = converter_config_reg_q[acg_pkg::CFG_RPT_MSB:acg_pkg::CFG_RPT_LSB];
   wire logic [4:0] divide = converter_config_reg_q[acg_pkg::CFG_DIV_MSB:acg_pkg::CFG_DIV_LSB];
   wire logic wr_cfg = sfr_wr && (sfr_addr == acg_pkg::ADDR_CONFIG);
   wire logic wr_hi = sfr_wr && (sfr_addr == acg_pkg::ADDR_RESULT_HIGH);
   wire logic wr_lo = sfr_wr && (sfr_addr == acg_pkg::ADDR_RESULT_LOW);
   wire logic wr_gain = wr_lo && gain_prog;
   wire logic wr_gain_high = wr_gain && (gain_index_q == acg_pkg::IDX_GAIN_HIGH);
   wire logic wr_gain_low = wr_gain && (gain_index_q == acg_pkg::IDX_GAIN_LOW);
   wire logic wr_gain_add = wr_gain && (gain_index_q == acg_pkg::IDX_ADDITIONAL_GAIN);
   // Repeat total: 00 one, 01 four, 10 eight, 11 sixteen for the full 16-bit sum.
   wire logic [4:0] rpt_total = (rpt == 2'b00) ? 5'h01 : (rpt == 2'b01) ? 5'h04 :
      (rpt == 2'b10) ? 5'h08 : 5'h10;
   wire logic start_edge = conv_start_s2_q && !conv_start_s3_q;
   wire logic last_conv = ({1'b0, done_cnt_q} + 5'h01) >= rpt_total;
   wire logic [ACC_W-1:0] sample_ext = {{(ACC_W-12){1'b0}}, sample_data};

   // Burst mode runs from a prescaled source capped at 30 MHz; otherwise every system edge.
   wire logic pre_wrap = (pre_q == 2'(acg_pkg::BURST_PRESCALE_CYC - 1));
   wire logic src_tick_d = burst_enable ? pre_wrap : 1'b1;

   acg_divider #(.W(5)) u_div (
      .clk(clk),
      .rst(rst),
      .src_tick(src_tick_q),
      .divide(divide),
      .sar_tick(sar_tick)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         pre_q <= 2'h0;
         src_tick_q <= 1'b0;
         sar_conversion_clock <= 1'b0;
      end else begin
         pre_q <= (!burst_enable || pre_wrap) ? 2'h0 : pre_q + 2'h1;
         src_tick_q <= src_tick_d;
         sar_conversion_clock <= sar_tick;
      end
   end

   // Two flops settle the asynchronous start pin; the third only serves the edge detector.
   always_ff @(posedge clk) begin
      if (rst) begin
         conv_start_s1_q <= 1'b0;
         conv_start_s2_q <= 1'b0;
         conv_start_s3_q <= 1'b0;
      end else begin
         conv_start_s1_q <= conv_start;
         conv_start_s2_q <= conv_start_s1_q;
         conv_start_s3_q <= conv_start_s2_q;
      end
   end

   // Gain registers are write-only; the index register itself is never read back.
   always_ff @(posedge clk) begin
      if (rst) begin
         converter_config_reg_q <= acg_pkg::RST_CONFIG;
      end else if (wr_cfg) begin
         converter_config_reg_q <= sfr_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gain_index_q <= 8'h00;
      end else if (wr_hi && gain_prog) begin
         gain_index_q <= sfr_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gain_high_reg_q <= acg_pkg::RST_GAIN_HIGH;
      end else if (wr_gain_high) begin
         gain_high_reg_q <= sfr_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gain_low_reg_q <= acg_pkg::RST_GAIN_LOW;
      end else if (wr_gain_low) begin
         gain_low_reg_q <= sfr_wdata;
      end
   end

   // Reserved bits are kept as written; only the lowest bit reaches the gain output.
   always_ff @(posedge clk) begin
      if (rst) begin
         additional_gain_reg_q <= acg_pkg::RST_ADDITIONAL_GAIN;
      end else if (wr_gain_add) begin
         additional_gain_reg_q <= sfr_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         gain_word <= 12'h000;
         gain_add_bit <= 1'b0;
      end else begin
         gain_word <= {gain_high_reg_q, gain_low_reg_q[7:4]};
         gain_add_bit <= additional_gain_reg_q[acg_pkg::GAIN_ADD_BIT];
      end
   end

   // Sequencer: non-burst waits for a start per conversion; burst self-times the series.
   always_ff @(posedge clk) begin
      if (rst) begin
         state_q <= acg_pkg::ACG_IDLE;
         acc_q <= '0;
         done_cnt_q <= 4'h0;
         tick_cnt_q <= 8'h00;
         conv_request <= 1'b0;
         conversion_done_flag <= 1'b0;
         window_compare_flag <= 1'b0;
         busy <= 1'b0;
      end else begin
         conv_request <= 1'b0;
         conversion_done_flag <= 1'b0;
         window_compare_flag <= 1'b0;
         case (state_q)
            acg_pkg::ACG_IDLE: begin
               if (start_edge && !gain_prog) begin
                  state_q <= acg_pkg::ACG_CONV;
                  acc_q <= '0;
                  done_cnt_q <= 4'h0;
                  tick_cnt_q <= 8'h00;
                  conv_request <= 1'b1;
                  busy <= 1'b1;
               end
            end
            acg_pkg::ACG_WAIT: begin
               if (start_edge) begin
                  state_q <= acg_pkg::ACG_CONV;
                  tick_cnt_q <= 8'h00;
                  conv_request <= 1'b1;
               end
            end
            acg_pkg::ACG_CONV: begin
               if (sar_tick && tick_cnt_q != 8'(CONV_TICKS)) tick_cnt_q <= tick_cnt_q + 8'h01;
               if (sample_valid) begin
                  acc_q <= acc_q + sample_ext;
                  done_cnt_q <= done_cnt_q + 4'h1;
                  if (last_conv) begin
                     state_q <= acg_pkg::ACG_IDLE;
                     conversion_done_flag <= 1'b1;
                     window_compare_flag <= 1'b1;
                     busy <= 1'b0;
                  end else if (burst_enable) begin
                     tick_cnt_q <= 8'h00;
                     conv_request <= 1'b1;
                  end else begin
                     state_q <= acg_pkg::ACG_WAIT;
                  end
               end
            end
            default: state_q <= acg_pkg::ACG_IDLE;
         endcase
      end
   end

   // Reads: configuration and the accumulated result pair; others read zero.
   wire logic [7:0] rd_mux = (sfr_addr == acg_pkg::ADDR_CONFIG) ? converter_config_reg_q :
      (sfr_addr == acg_pkg::ADDR_RESULT_HIGH) ? acc_q[15:8] :
      (sfr_addr == acg_pkg::ADDR_RESULT_LOW) ? acc_q[7:0] : 8'h00;
   always_ff @(posedge clk) begin
      if (rst) sfr_rdata <= 8'h00;
      else sfr_rdata <= rd_mux;
   end
endmodule // acg_config

// ===== test/acg_config_sva.sv
// Port-level assertions for the converter configuration block.
`timescale 1ns/10ps
module acg_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_rdata,
   input wire logic burst_enable,
   input wire logic sample_valid,
   input wire logic sar_conversion_clock,
   input wire logic conv_request,
   input wire logic conversion_done_flag,
   input wire logic window_compare_flag,
   input wire logic [11:0] gain_word,
   input wire logic gain_add_bit,
   input wire logic busy
);
   // Shadow of the configuration register, so clock checks know the divider value.
   logic [7:0] cfg_q;
   wire lo_wr = sfr_wr && sfr_addr == acg_pkg::ADDR_RESULT_LOW;
   always_ff @(posedge clk) begin
      if (rst) cfg_q <= acg_pkg::RST_CONFIG;
      else if (sfr_wr && sfr_addr == acg_pkg::ADDR_CONFIG) cfg_q <= sfr_wdata;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   property p_done_pair; conversion_done_flag == window_compare_flag; endproperty
   a_done_pair: assert property (p_done_pair) else $error("flags differ");
   property p_done_src; conversion_done_flag |-> !busy && ($past(sample_valid) || $past(sample_valid, 2)); endproperty
   a_done_src: assert property (p_done_src) else $error("done without sample");
   property p_req_busy; conv_request |-> busy; endproperty
   a_req_busy: assert property (p_req_busy) else $error("request while idle");
   property p_gain_rst; $fell(rst) |=> gain_word == 12'hfc0 && gain_add_bit; endproperty
   a_gain_rst: assert property (p_gain_rst) else $error("gain reset value");
   property p_gain_src; $changed({gain_word, gain_add_bit}) |-> $past(rst) || $past(rst, 2) || $past(lo_wr) || $past(lo_wr, 2) || $past(lo_wr, 3); endproperty
   a_gain_src: assert property (p_gain_src) else $error("gain changed unasked");
   property p_rd_cfg; !$past(rst) && $past(sfr_addr) == acg_pkg::ADDR_CONFIG && !$past(sfr_wr) |-> sfr_rdata == cfg_q; endproperty
   a_rd_cfg: assert property (p_rd_cfg) else $error("config readback");
   property p_rd_gain; !$past(rst) && $past(sfr_addr) == acg_pkg::IDX_ADDITIONAL_GAIN |-> sfr_rdata == 8'h00; endproperty
   a_rd_gain: assert property (p_rd_gain) else $error("gain readable");
   property p_div_sys; !burst_enable && $past(!burst_enable) && sar_conversion_clock && cfg_q[7:3] == 5'h01 && $stable(cfg_q) |=> !sar_conversion_clock ##1 sar_conversion_clock; endproperty
   a_div_sys: assert property (p_div_sys) else $error("system divide");
   property p_div_bst; burst_enable && $past(burst_enable, 4) && sar_conversion_clock && cfg_q[7:3] == 5'h00 && $stable(cfg_q) |=> !sar_conversion_clock [*3] ##1 sar_conversion_clock; endproperty
   a_div_bst: assert property (p_div_bst) else $error("burst divide");
endmodule // acg_sva
bind acg_config acg_sva u_sva (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
   .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .burst_enable(burst_enable),
   .sample_valid(sample_valid), .sar_conversion_clock(sar_conversion_clock),
   .conv_request(conv_request), .conversion_done_flag(conversion_done_flag),
   .window_compare_flag(window_compare_flag), .gain_word(gain_word),
   .gain_add_bit(gain_add_bit), .busy(busy));

// ===== test/tb_top.sv
// Self-checking bench for the converter configuration block.
`timescale 1ns/10ps
module tb_top;
   logic clk, rst, sfr_wr, burst_enable, conv_start, sample_valid, gain_add_bit, busy;
   logic sar_conversion_clock, conv_request, conversion_done_flag, window_compare_flag;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [11:0] sample_data, gain_word;
   int errors = 0;
   int total_checks = 0;
   acg_config dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .burst_enable(burst_enable),
      .conv_start(conv_start), .sample_valid(sample_valid), .sample_data(sample_data),
      .sar_conversion_clock(sar_conversion_clock), .conv_request(conv_request),
      .conversion_done_flag(conversion_done_flag), .window_compare_flag(window_compare_flag),
      .gain_word(gain_word), .gain_add_bit(gain_add_bit), .busy(busy));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      @(negedge clk);
      d = sfr_rdata;
   endtask
   task automatic t_gain();
      logic [7:0] d;
      logic [7:0] seq [6] = '{8'h04, 8'h6c, 8'h07, 8'ha0, 8'h08, 8'h00};
      chk(gain_word, 16'h0fc0);
      chk(gain_add_bit, 16'h0001);
      rd(acg_pkg::ADDR_CONFIG, d);
      chk(d, acg_pkg::RST_CONFIG);
      wr(acg_pkg::ADDR_CONFIG, 8'h01);
      // A start pulse while gain programming is on must not launch a conversion.
      conv_start = 1'b1;
      repeat (6) begin
         @(negedge clk);
         chk(conv_request, 16'h0000);
      end
      conv_start = 1'b0;
      for (int i = 0; i < 6; i += 2) begin
         wr(acg_pkg::ADDR_RESULT_HIGH, seq[i]);
         wr(acg_pkg::ADDR_RESULT_LOW, seq[i + 1]);
      end
      wr(acg_pkg::ADDR_CONFIG, 8'h00);
      chk(gain_word, 16'h06ca);
      chk(gain_add_bit, 16'h0000);
      // With programming off the low result write must not reach the gain path.
      wr(acg_pkg::ADDR_RESULT_LOW, 8'hff);
      rd(acg_pkg::ADDR_RESULT_LOW, d);
      chk(d, 16'h0000);
      chk(gain_word, 16'h06ca);
      chk(gain_add_bit, 16'h0000);
      rd(acg_pkg::IDX_ADDITIONAL_GAIN, d);
      chk(d, 16'h0000);
   endtask
   task automatic t_conv(input logic [1:0] rpt, input logic bst);
      logic [15:0] sum;
      logic [7:0] hi, lo;
      int n, k;
      n = (rpt == 2'b11) ? 16 : (rpt == 2'b00) ? 1 : 4 * rpt;
      sum = 16'h0000;
      burst_enable = bst;
      // Divide values are rounded up, so neither conversion clock passes its target.
      wr(acg_pkg::ADDR_CONFIG, {4'h0, ~bst, rpt, 1'b0});
      for (int i = 0; i < n; i++) begin
         if (!bst || i == 0) begin
            repeat (8) begin
               @(negedge clk);
               chk(conv_request, 16'h0000);
            end
            conv_start = 1'b1;
         end
         k = 0;
         while (conv_request !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
         end
         chk(conv_request, 16'h0001);
         chk(busy, 16'h0001);
         conv_start = 1'b0;
         @(negedge clk);
         sample_data = 12'hf00 + 12'(i * 17);
         sample_valid = 1'b1;
         sum = sum + 16'(sample_data);
         @(negedge clk);
         sample_valid = 1'b0;
      end
      k = 0;
      while (conversion_done_flag !== 1'b1 && k < 20) begin
         @(negedge clk);
         k++;
      end
      chk(window_compare_flag, 16'h0001);
      chk(conversion_done_flag, 16'h0001);
      chk(busy, 16'h0000);
      rd(acg_pkg::ADDR_RESULT_HIGH, hi);
      rd(acg_pkg::ADDR_RESULT_LOW, lo);
      chk({hi, lo}, sum);
   endtask
   task automatic wrap_up();
      if (errors == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      {sfr_wr, burst_enable, conv_start, sample_valid} = 4'h0;
      {sfr_addr, sfr_wdata, sample_data} = 28'h0;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      t_gain();
      for (int r = 0; r < 8; r++) t_conv(r[1:0], r[2]);
      wrap_up();
   end
   initial begin
      #200000;
      errors++;
      wrap_up();
   end
endmodule // tb_top
